//--- logic/mpc_pin_config.sv
`timescale 1ns/1ps
module mpc_pin_config
  import mpc_pkg::*;
#(
  parameter int NUM_PINS = MPC_NUM_PINS
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                cfg_wr,
  input  wire logic [7:0]          cfg_addr,
  input  wire logic [3:0]          cfg_be,
  input  wire logic [31:0]         cfg_wdata,
  output logic      [31:0]         cfg_rdata,
  input  wire logic                ldr_wr,
  input  wire logic [31:0]         ldr_wdata,
  input  wire logic [2:0]          device_mode,
  input  wire logic                mini_pci_mode,
  input  wire logic [1:0]          powerdown_filter_setting,
  input  wire logic                pin2_event_enable,
  input  wire logic                power_event_clear,
  input  wire logic                pm_clock_request,
  input  wire logic [NUM_PINS-1:0] multi_purpose_pins_all_in,
  output logic      [NUM_PINS-1:0] multi_purpose_pins_all_out,
  output logic      [NUM_PINS-1:0] multi_purpose_pins_all_oe,
  output logic      [NUM_PINS-1:0] multi_purpose_pin_value,
  output logic                     power_event_status,
  output logic                     clkrun_hold
);
  logic [31:0]         ctrl;
  logic [31:0]         next_ctrl;
  logic [31:0]         next_rdata;
  logic [NUM_PINS-1:0] pins_sync;
  logic [NUM_PINS-1:0] next_out;
  logic [NUM_PINS-1:0] next_oe;
  logic [NUM_PINS-1:0] next_val;
  logic                par_mode;
  logic                pd_enabled;
  logic                event_level;
  logic                next_hold;

  function automatic logic [1:0] pin_field(input logic [31:0] r, input int idx);
    pin_field = r[2*idx +: 2];
  endfunction : pin_field

  mpc_sync #(.WIDTH(NUM_PINS)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (multi_purpose_pins_all_in),
    .sync_out (pins_sync)
  );

  assign par_mode    = (device_mode == MPC_MODE_PAR_A) || (device_mode == MPC_MODE_PAR_B);
  assign pd_enabled  = (powerdown_filter_setting != MPC_FILTER_OFF);
  assign event_level = pins_sync[2] ^ ctrl[MPC_PIN2_POL_BIT];

  // loader writes all fields except bits 31, 28 and 27, which stay zero; bus writes honour byte enables but never bit 26
  always_comb begin
    next_ctrl = ctrl;
    if (ldr_wr) begin
      next_ctrl = ldr_wdata;
    end else if (cfg_wr && cfg_addr == MPC_REG_OFFSET) begin
      for (int b = 0; b < 4; b++) begin
        if (cfg_be[b]) begin
          next_ctrl[8*b +: 8] = cfg_wdata[8*b +: 8];
        end
      end
      next_ctrl[MPC_RSV_LOADER_BIT] = ctrl[MPC_RSV_LOADER_BIT];
    end
    // reserved 23:22 and 25:24 are stored as written; software keeps them zero
    next_ctrl[31]              = 1'b0;
    next_ctrl[MPC_MINI_BIT]    = 1'b0;
    next_ctrl[MPC_RSV_ONE_BIT] = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= MPC_REG_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_comb begin
    next_rdata                  = ctrl;
    next_rdata[MPC_MINI_BIT]    = mini_pci_mode;
    next_rdata[MPC_RSV_ONE_BIT] = 1'b1;
  end

  // read data comes from a flop; a read sees a write one clock after it lands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= MPC_REG_RESET | (32'h0000_0001 << MPC_RSV_ONE_BIT);
    end else begin
      cfg_rdata <= next_rdata;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      next_oe[i]  = 1'b0;
      next_out[i] = 1'b0;
      next_val[i] = pins_sync[i] ^ (pin_field(ctrl, i) == MPC_CFG_IN_INVERT);
      if (pin_field(ctrl, i) == MPC_CFG_OUT_LOW || pin_field(ctrl, i) == MPC_CFG_OUT_HIGH) begin
        next_oe[i]  = 1'b1;
        next_out[i] = (pin_field(ctrl, i) == MPC_CFG_OUT_HIGH);
        next_val[i] = next_out[i];
      end
    end
    // parallel port takes pin 0, driven low as unused
    if (par_mode) begin
      next_oe[0]  = 1'b1;
      next_out[0] = 1'b0;
      next_val[0] = 1'b0;
    end
    if (pd_enabled) begin
      next_oe[1]  = 1'b1;
      next_out[1] = 1'b0;
      next_val[1] = 1'b0;
    end
    // pin 2 becomes the event input
    if (pin2_event_enable) begin
      next_oe[2]  = 1'b0;
      next_out[2] = 1'b0;
      next_val[2] = event_level;
    end
  end

  // pins follow config one clock later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      multi_purpose_pins_all_out <= '0;
      multi_purpose_pins_all_oe  <= '0;
      multi_purpose_pin_value    <= '0;
    end else begin
      multi_purpose_pins_all_out <= next_out;
      multi_purpose_pins_all_oe  <= next_oe;
      multi_purpose_pin_value    <= next_val;
    end
  end

  // sticky event, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_event_status <= 1'b0;
    end else if (pin2_event_enable && event_level) begin
      power_event_status <= 1'b1;
    end else if (power_event_clear) begin
      power_event_status <= 1'b0;
    end
  end

  // in mini PCI mode only: follow power states when bit 29 set; bit 30 releases the clock
  always_comb begin
    next_hold = 1'b1;
    if (mini_pci_mode) begin
      if (ctrl[MPC_CLK_DIS_BIT]) begin
        next_hold = 1'b0;
      end else if (ctrl[MPC_CLK_PM_BIT]) begin
        next_hold = pm_clock_request;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkrun_hold <= 1'b1;
    end else begin
      clkrun_hold <= next_hold;
    end
  end

  // output field drives pin one clock later
  out_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_field(ctrl, 5) == MPC_CFG_OUT_HIGH) |=> (multi_purpose_pins_all_oe[5] && multi_purpose_pins_all_out[5]))
    else $error("pin 5 not driven high");
  reset_fields_a: assert property (@(posedge clk) $rose(rst_n) |-> ctrl[21:0] == 22'h0)
    else $error("fields not zero after reset");
  par_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    par_mode |=> multi_purpose_pins_all_oe[0])
    else $error("pin 0 not forced in parallel mode");
  pd_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    pd_enabled |=> multi_purpose_pins_all_oe[1])
    else $error("pin 1 not forced");
  event_in_a: assert property (@(posedge clk) disable iff (!rst_n)
    pin2_event_enable |=> !multi_purpose_pins_all_oe[2])
    else $error("pin 2 driven as event input");
  event_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pin2_event_enable && event_level) |=> power_event_status)
    else $error("event status not set");
  keep_bit26_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_wr && !ldr_wr) |=> $stable(ctrl[MPC_RSV_LOADER_BIT]))
    else $error("bit 26 changed by bus write");
  // mode status read, one clock behind
  mini_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> (cfg_rdata[MPC_MINI_BIT] == $past(mini_pci_mode) && cfg_rdata[MPC_RSV_ONE_BIT]))
    else $error("status bits wrong");
  clk_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mini_pci_mode && ctrl[MPC_CLK_DIS_BIT]) |=> !clkrun_hold)
    else $error("clock still held");
  clk_std_a: assert property (@(posedge clk) disable iff (!rst_n)
    !mini_pci_mode |=> clkrun_hold)
    else $error("clock released in pci mode");
  clk_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mini_pci_mode && !ctrl[MPC_CLK_DIS_BIT] && ctrl[MPC_CLK_PM_BIT]) |=> (clkrun_hold == $past(pm_clock_request)))
    else $error("clock hold not following power request");

  cov_event_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(power_event_status));
  cov_par_c: cover property (@(posedge clk) disable iff (!rst_n) par_mode && pin_field(ctrl, 0) == MPC_CFG_IN_PLAIN);
  cov_inv_c: cover property (@(posedge clk) disable iff (!rst_n) pin_field(ctrl, 3) == MPC_CFG_IN_INVERT);
  cov_rel_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(clkrun_hold));
endmodule : mpc_pin_config

//--- logic/mpc_pkg.sv
package mpc_pkg;
  localparam int          MPC_NUM_PINS       = 11;
  localparam logic [7:0]  MPC_REG_OFFSET     = 8'h04;
  localparam logic [1:0]  MPC_CFG_IN_PLAIN   = 2'h0;
  localparam logic [1:0]  MPC_CFG_IN_INVERT  = 2'h1;
  localparam logic [1:0]  MPC_CFG_OUT_LOW    = 2'h2;
  localparam logic [1:0]  MPC_CFG_OUT_HIGH   = 2'h3;
  localparam logic [1:0]  MPC_CFG_RESET      = 2'h0;
  localparam int          MPC_RSV_A_LSB      = 22;
  localparam int          MPC_RSV_B_LSB      = 24;
  localparam int          MPC_RSV_LOADER_BIT = 26;
  localparam int          MPC_MINI_BIT       = 27;
  localparam int          MPC_RSV_ONE_BIT    = 28;
  localparam int          MPC_CLK_PM_BIT     = 29;
  localparam int          MPC_CLK_DIS_BIT    = 30;
  localparam int          MPC_PIN2_POL_BIT   = 4;
  localparam logic [2:0]  MPC_MODE_PAR_A     = 3'h1;
  localparam logic [2:0]  MPC_MODE_PAR_B     = 3'h5;
  localparam logic [1:0]  MPC_FILTER_OFF     = 2'h0;
  localparam logic [31:0] MPC_REG_RESET      = 32'h0000_0000;
endpackage : mpc_pkg

//--- logic/mpc_sync.sv
`timescale 1ns/1ps
module mpc_sync #(
  parameter int WIDTH = 11
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : mpc_sync

//--- bench/mpc_board.sv
`timescale 1ns/1ps
module mpc_board
  import mpc_pkg::*;
(
  input  wire logic [MPC_NUM_PINS-1:0] drive_out,
  input  wire logic [MPC_NUM_PINS-1:0] drive_oe,
  input  wire logic [MPC_NUM_PINS-1:0] board_level,
  output logic      [MPC_NUM_PINS-1:0] pin_level
);
  // a driven pin follows the device, an undriven one the board strap
  always_comb begin
    for (int i = 0; i < MPC_NUM_PINS; i++) begin
      pin_level[i] = drive_oe[i] ? drive_out[i] : board_level[i];
    end
  end
endmodule : mpc_board

//--- bench/tb.sv
`timescale 1ns/1ps
module tb
  import mpc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cfg_wr = 1'b0;
  logic [7:0]  cfg_addr = MPC_REG_OFFSET;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [3:0]  be = 4'hF;
  logic        ldr_wr = 1'b0;
  logic [31:0] ldr_wdata = 32'h0000_0000;
  logic [2:0]  device_mode = 3'h0;
  logic        mini = 1'b0;
  logic [1:0]  pd_filter = 2'h0;
  logic        ev_en = 1'b0;
  logic        ev_clr = 1'b0;
  logic        pm_req = 1'b0;
  logic [10:0] board = 11'h000;
  logic [10:0] pins, pout, poe, pval;
  logic [31:0] rdata;
  logic        evt, hold;
  int          err_total = 0;
  int          checked = 0;
  always #5 clk = ~clk;
  mpc_pin_config u_mpc_pin_config (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(be), .cfg_wdata(cfg_wdata), .cfg_rdata(rdata), .ldr_wr(ldr_wr), .ldr_wdata(ldr_wdata),
    .device_mode(device_mode), .mini_pci_mode(mini), .powerdown_filter_setting(pd_filter),
    .pin2_event_enable(ev_en), .power_event_clear(ev_clr), .pm_clock_request(pm_req),
    .multi_purpose_pins_all_in(pins), .multi_purpose_pins_all_out(pout),
    .multi_purpose_pins_all_oe(poe), .multi_purpose_pin_value(pval),
    .power_event_status(evt), .clkrun_hold(hold));
  mpc_board u_mpc_board (.drive_out(pout), .drive_oe(poe), .board_level(board), .pin_level(pins));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // settle covers one edge to the pins, the two-flop input sync and the value flop
  task automatic wr(input logic [31:0] d, input logic [7:0] a = MPC_REG_OFFSET);
    @(negedge clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    repeat (4) @(negedge clk);
  endtask : wr
  // let the pin change pass the input sync first, else the still-active event wins over the clear
  task automatic clear_event();
    repeat (3) @(negedge clk);
    ev_clr = 1'b1;
    @(negedge clk);
    ev_clr = 1'b0;
    repeat (2) @(negedge clk);
  endtask : clear_event
  task automatic t_reset();
    chk(rdata, 32'h1000_0000);
    chk(32'({poe, pout, evt}), 32'h0000_0000);
    chk(32'(hold), 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset
  task automatic t_out();
    wr(32'h003F_FFFF);
    chk(32'({poe, pout}), 32'h003F_FFFF);
    chk(rdata, 32'h103F_FFFF);
    wr(32'h002A_AAAA);
    chk(32'({poe, pout}), 32'h003F_F800);
    wr(32'h0000_0C00);
    chk(32'({poe, pout}), 32'h0001_0020);
    $display("test outputs done");
  endtask : t_out
  task automatic t_in();
    board = 11'h5A3;
    wr(32'h0015_5555);
    chk(32'({poe, pval}), 32'h0000_025C);
    wr(32'h0000_0000);
    chk(32'(pval), 32'h0000_05A3);
    board = 11'h000;
    $display("test inputs done");
  endtask : t_in
  task automatic t_forced();
    for (int i = 1; i < 4; i++) begin
      device_mode = i[0] ? MPC_MODE_PAR_A : MPC_MODE_PAR_B;
      pd_filter = 2'(i);
      wr(32'h0000_000F);
      chk(32'({poe[1:0], pout[1:0]}), 32'h0000_000C);
    end
    device_mode = 3'h0;
    pd_filter = MPC_FILTER_OFF;
    wr(32'h0000_000F);
    chk(32'({poe[1:0], pout[1:0]}), 32'h0000_000F);
    $display("test forced done");
  endtask : t_forced
  task automatic t_event();
    board = 11'h004;
    wr(32'h0000_0000);
    chk(32'(evt), 32'h0000_0000);
    ev_en = 1'b1;
    repeat (4) @(negedge clk);
    chk(32'(evt), 32'h0000_0001);
    board = 11'h000;
    clear_event();
    chk(32'(evt), 32'h0000_0000);
    wr(32'h0000_0010);
    chk(32'(evt), 32'h0000_0001);
    board = 11'h004;
    clear_event();
    chk(32'(evt), 32'h0000_0000);
    ev_en = 1'b0;
    $display("test event done");
  endtask : t_event
  task automatic t_clock();
    mini = 1'b1;
    wr(32'h0000_0000);
    chk(rdata, 32'h1800_0000);
    chk(32'(hold), 32'h0000_0001);
    wr(32'h4000_0000);
    chk(32'(hold), 32'h0000_0000);
    wr(32'h2000_0000);
    chk(32'(hold), 32'h0000_0000);
    pm_req = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(hold), 32'h0000_0001);
    mini = 1'b0;
    wr(32'h4000_0000);
    chk(32'(hold), 32'h0000_0001);
    $display("test clock done");
  endtask : t_clock
  task automatic t_bits();
    wr(32'h0400_0000);
    chk(rdata, 32'h1000_0000);
    wr(32'h0000_0003, 8'h08);
    chk(rdata, 32'h1000_0000);
    ldr_wdata = 32'h0400_0000;
    ldr_wr = 1'b1;
    @(negedge clk);
    ldr_wr = 1'b0;
    wr(32'h0000_0000);
    chk(rdata, 32'h1400_0000);
    be = 4'h1;
    wr(32'hFFFF_FF0C);
    chk(rdata, 32'h1400_000C);
    chk(32'({poe[1], pout[1]}), 32'h0000_0003);
    be = 4'hF;
    $display("test bits done");
  endtask : t_bits
  task automatic results();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_out();
    t_in();
    t_forced();
    t_event();
    t_clock();
    t_bits();
    results();
  end
  // the tests need well under a thousand cycles
  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule : tb
